/* File: logic/pmdp_pkg.sv */
package pmdp_pkg;

	// System clock and MII clock rates
	localparam int CLK_SYS_KHZ = 200000;
	localparam int MII_100_KHZ = 25000;
	localparam int MII_10_KHZ = 2500;

	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] DIV_100 = CNT_W'(CLK_SYS_KHZ / MII_100_KHZ);
	localparam logic [CNT_W-1:0] DIV_10 = CNT_W'(CLK_SYS_KHZ / MII_10_KHZ);
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

	localparam int NIB_W = 4;
	localparam int RX_FIFO_DEPTH = 4;
	localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

	typedef enum logic [2:0] {
		PMDP_RX_IDLE = 3'b001,
		PMDP_RX_CARRIER = 3'b010,
		PMDP_RX_FRAME = 3'b100
	} pmdp_rx_state_t;

	// Full period of an MII clock in system cycles
	function automatic logic [CNT_W-1:0] pmdp_div(input logic speed_100);
		pmdp_div = speed_100 ? DIV_100 : DIV_10;
	endfunction

	// Clock is high during the first half of the period
	function automatic logic pmdp_clk_level(input logic [CNT_W-1:0] cnt, input logic speed_100);
		pmdp_clk_level = cnt < (pmdp_div(speed_100) >> 1);
	endfunction

	// Last count of the period: the next cycle is a rising edge
	function automatic logic pmdp_wrap(input logic [CNT_W-1:0] cnt, input logic speed_100);
		pmdp_wrap = cnt >= (pmdp_div(speed_100) - CNT_ONE);
	endfunction

endpackage

/* File: logic/pmdp_mii_if.sv */
`timescale 1ns/1ps
interface pmdp_mii_if;
	import pmdp_pkg::*;

	logic rx_clk_o;
	logic rx_clk_oe;
	logic [NIB_W-1:0] rxd_o;
	logic rxd_oe;
	logic rx_dv_o;
	logic rx_dv_oe;
	logic rx_er_o;
	logic rx_er_oe;
	logic rx_clk;
	logic [NIB_W-1:0] rxd;
	logic rx_dv;
	logic rx_er;
	logic tx_clk;
	logic [NIB_W-1:0] txd;
	logic tx_en;
	logic tx_er;
	logic rx_bus_tristate_req;

	// Undriven shared receive bus reads as low (weak pull-down)
	assign rx_clk = rx_clk_oe ? rx_clk_o : 1'b0;
	assign rxd = rxd_oe ? rxd_o : NIB_ZERO;
	assign rx_dv = rx_dv_oe ? rx_dv_o : 1'b0;
	assign rx_er = rx_er_oe ? rx_er_o : 1'b0;

	modport phy (
		output rx_clk_o,
		output rx_clk_oe,
		output rxd_o,
		output rxd_oe,
		output rx_dv_o,
		output rx_dv_oe,
		output rx_er_o,
		output rx_er_oe,
		output tx_clk,
		input txd,
		input tx_en,
		input tx_er,
		input rx_bus_tristate_req
	);

	modport mac (
		input rx_clk,
		input rxd,
		input rx_dv,
		input rx_er,
		input tx_clk,
		output txd,
		output tx_en,
		output tx_er,
		output rx_bus_tristate_req
	);

endinterface

/* File: logic/pmdp_fifo.sv */
`timescale 1ns/1ps
module pmdp_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [CNT_W-1:0] FILL_FULL = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] FILL_ONE = CNT_W'(1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] fill;
	} pmdp_fifo_state_t;

	pmdp_fifo_state_t s_reg;
	pmdp_fifo_state_t s_next;
	logic push;
	logic pop;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_ONE;
	endfunction

	assign in_ready = s_reg.fill != FILL_FULL;
	assign out_valid = s_reg.fill != '0;
	assign out_data = s_reg.mem[s_reg.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wr_ptr] = in_data;
			s_next.wr_ptr = ptr_inc(s_reg.wr_ptr);
		end
		if (pop) begin
			s_next.rd_ptr = ptr_inc(s_reg.rd_ptr);
		end
		if (push && !pop) begin
			s_next.fill = s_reg.fill + FILL_ONE;
		end else if (pop && !push) begin
			s_next.fill = s_reg.fill - FILL_ONE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

/* File: logic/pmdp_phy_end.sv */
`timescale 1ns/1ps
module pmdp_phy_end
	import pmdp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	pmdp_mii_if.phy mii,
	input wire logic speed_100,
	input wire logic link_up,
	input wire logic carrier_sense,
	input wire logic line_rx_valid,
	output logic line_rx_ready,
	input wire logic [NIB_W-1:0] line_rx_data,
	input wire logic start_delim_seen,
	input wire logic end_delim_seen,
	input wire logic signal_error,
	input wire logic false_carrier,
	input wire logic frame_error,
	output logic line_tx_valid,
	output logic [NIB_W-1:0] line_tx_data,
	output logic line_tx_halt
);

	typedef struct packed {
		pmdp_rx_state_t rx_state;
		logic [CNT_W-1:0] rx_cnt;
		logic rx_clk;
		logic [NIB_W-1:0] rxd;
		logic rx_dv;
		logic rx_er;
		logic start_pend;
		logic end_pend;
		logic fc_pend;
		logic ferr_pend;
		logic link_prev;
		logic [CNT_W-1:0] tx_cnt;
		logic tx_clk;
		logic tx_valid;
		logic [NIB_W-1:0] tx_data;
		logic tx_halt;
		logic tri_s1;
		logic tri_s2;
		logic [NIB_W-1:0] txd_s1;
		logic [NIB_W-1:0] txd_s2;
		logic txen_s1;
		logic txen_s2;
		logic txer_s1;
		logic txer_s2;
	} pmdp_phy_state_t;

	pmdp_phy_state_t s_reg;
	pmdp_phy_state_t s_next;

	logic fifo_valid;
	logic fifo_pop;
	logic [NIB_W-1:0] fifo_data;
	logic rx_rise;
	logic realign;

	// Line nibbles wait here for the next receive clock edge
	pmdp_fifo #(
		.WIDTH(NIB_W),
		.DEPTH(RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(line_rx_valid),
		.in_ready(line_rx_ready),
		.in_data(line_rx_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	assign rx_rise = pmdp_wrap(s_reg.rx_cnt, speed_100);
	// The nibble shown with valid's rise leaves the buffer at once, or it would repeat
	assign fifo_pop = rx_rise && fifo_valid && (((s_reg.rx_state == PMDP_RX_FRAME) && !s_reg.end_pend)
		|| ((s_reg.rx_state == PMDP_RX_CARRIER) && s_reg.start_pend));

	// 10M realigns on each carrier, 100M only when the link comes up
	always_comb begin
		if (speed_100) begin
			realign = link_up && !s_reg.link_prev;
		end else begin
			realign = carrier_sense && (s_reg.rx_state == PMDP_RX_IDLE);
		end
	end

	always_comb begin
		s_next = s_reg;

		s_next.tri_s1 = mii.rx_bus_tristate_req;
		s_next.tri_s2 = s_reg.tri_s1;
		s_next.txd_s1 = mii.txd;
		s_next.txd_s2 = s_reg.txd_s1;
		s_next.txen_s1 = mii.tx_en;
		s_next.txen_s2 = s_reg.txen_s1;
		s_next.txer_s1 = mii.tx_er;
		s_next.txer_s2 = s_reg.txer_s1;
		s_next.link_prev = link_up;

		// Receive clock divider; a realign restarts the period, so one short phase may occur
		if (realign) begin
			s_next.rx_cnt = CNT_ZERO;
		end else if (rx_rise) begin
			s_next.rx_cnt = CNT_ZERO;
		end else begin
			s_next.rx_cnt = s_reg.rx_cnt + CNT_ONE;
		end
		s_next.rx_clk = pmdp_clk_level(s_next.rx_cnt, speed_100);

		// Events may land between edges; hold them, a new event beats the clear
		s_next.start_pend = s_reg.start_pend || start_delim_seen;
		s_next.end_pend = s_reg.end_pend || end_delim_seen || signal_error;
		s_next.fc_pend = s_reg.fc_pend || false_carrier;
		s_next.ferr_pend = s_reg.ferr_pend || frame_error;

		if (rx_rise) begin
			case (s_reg.rx_state)
				PMDP_RX_IDLE: begin
					s_next.rx_dv = 1'b0;
					s_next.rx_er = 1'b0;
					s_next.start_pend = start_delim_seen;
					s_next.end_pend = end_delim_seen || signal_error;
					s_next.fc_pend = false_carrier;
					s_next.ferr_pend = frame_error;
				end
				PMDP_RX_CARRIER: begin
					if (s_reg.start_pend && fifo_valid) begin
						s_next.rx_state = PMDP_RX_FRAME;
						s_next.rx_dv = 1'b1;
						s_next.rxd = fifo_data;
						s_next.rx_er = 1'b0;
						s_next.start_pend = start_delim_seen;
						s_next.end_pend = end_delim_seen || signal_error;
					end else if (!carrier_sense) begin
						s_next.rx_state = PMDP_RX_IDLE;
						s_next.rx_er = 1'b0;
					end else begin
						s_next.rx_er = speed_100 && s_reg.fc_pend;
					end
					s_next.fc_pend = false_carrier;
				end
				PMDP_RX_FRAME: begin
					if (s_reg.end_pend) begin
						s_next.rx_state = carrier_sense ? PMDP_RX_CARRIER : PMDP_RX_IDLE;
						s_next.rx_dv = 1'b0;
						s_next.rx_er = 1'b0;
						s_next.end_pend = end_delim_seen || signal_error;
						s_next.start_pend = start_delim_seen;
					end else begin
						// Underrun repeats the last nibble
						if (fifo_valid) begin
							s_next.rxd = fifo_data;
						end
						s_next.rx_er = speed_100 && s_reg.ferr_pend;
					end
					s_next.ferr_pend = frame_error;
				end
				default: begin
					s_next.rx_state = PMDP_RX_IDLE;
					s_next.rx_dv = 1'b0;
					s_next.rx_er = 1'b0;
				end
			endcase
		end else if (s_reg.rx_state == PMDP_RX_IDLE && carrier_sense) begin
			s_next.rx_state = PMDP_RX_CARRIER;
		end

		// Transmit clock divider runs free from the reference
		if (pmdp_wrap(s_reg.tx_cnt, speed_100)) begin
			s_next.tx_cnt = CNT_ZERO;
		end else begin
			s_next.tx_cnt = s_reg.tx_cnt + CNT_ONE;
		end
		s_next.tx_clk = pmdp_clk_level(s_next.tx_cnt, speed_100);

		s_next.tx_valid = 1'b0;
		if (pmdp_wrap(s_reg.tx_cnt, speed_100) && s_reg.txen_s2) begin
			s_next.tx_valid = 1'b1;
			s_next.tx_data = s_reg.txd_s2;
			s_next.tx_halt = speed_100 && s_reg.txer_s2;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.rx_state <= PMDP_RX_IDLE;
			// Wrap at release, so the first transmit clock high phase is a full one
			s_reg.tx_cnt <= DIV_10 - CNT_ONE;
		end else begin
			s_reg <= s_next;
		end
	end

	// MAC holding the request high releases the shared receive bus
	assign mii.rx_clk_o = s_reg.rx_clk;
	assign mii.rx_clk_oe = !s_reg.tri_s2;
	assign mii.rxd_o = s_reg.rxd;
	assign mii.rxd_oe = !s_reg.tri_s2;
	assign mii.rx_dv_o = s_reg.rx_dv;
	assign mii.rx_dv_oe = !s_reg.tri_s2;
	assign mii.rx_er_o = s_reg.rx_er;
	assign mii.rx_er_oe = !s_reg.tri_s2;
	assign mii.tx_clk = s_reg.tx_clk;

	assign line_tx_valid = s_reg.tx_valid;
	assign line_tx_data = s_reg.tx_data;
	assign line_tx_halt = s_reg.tx_halt;

endmodule

/* File: logic/pmdp_mac_end.sv */
`timescale 1ns/1ps
module pmdp_mac_end
	import pmdp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	pmdp_mii_if.mac mii,
	input wire logic speed_100,
	input wire logic rx_release,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [NIB_W-1:0] tx_data,
	input wire logic tx_error,
	output logic rx_valid,
	output logic [NIB_W-1:0] rx_data,
	output logic rx_error,
	output logic rx_in_frame
);

	typedef struct packed {
		logic rxc_s1;
		logic rxc_s2;
		logic rxc_s3;
		logic [NIB_W-1:0] rxd_s1;
		logic [NIB_W-1:0] rxd_s2;
		logic dv_s1;
		logic dv_s2;
		logic er_s1;
		logic er_s2;
		logic txc_s1;
		logic txc_s2;
		logic txc_s3;
		logic rx_valid;
		logic [NIB_W-1:0] rx_data;
		logic rx_error;
		logic rx_in_frame;
		logic tx_en;
		logic [NIB_W-1:0] txd;
		logic tx_er;
		logic tri_req;
	} pmdp_mac_state_t;

	pmdp_mac_state_t s_reg;
	pmdp_mac_state_t s_next;
	logic rx_edge;
	logic tx_edge;

	// Data and clock share the same synchroniser depth, so they stay aligned
	assign rx_edge = s_reg.rxc_s2 && !s_reg.rxc_s3;
	assign tx_edge = s_reg.txc_s2 && !s_reg.txc_s3;
	assign tx_ready = tx_edge;

	always_comb begin
		s_next = s_reg;
		s_next.rxc_s1 = mii.rx_clk;
		s_next.rxc_s2 = s_reg.rxc_s1;
		s_next.rxc_s3 = s_reg.rxc_s2;
		s_next.rxd_s1 = mii.rxd;
		s_next.rxd_s2 = s_reg.rxd_s1;
		s_next.dv_s1 = mii.rx_dv;
		s_next.dv_s2 = s_reg.dv_s1;
		s_next.er_s1 = mii.rx_er;
		s_next.er_s2 = s_reg.er_s1;
		s_next.txc_s1 = mii.tx_clk;
		s_next.txc_s2 = s_reg.txc_s1;
		s_next.txc_s3 = s_reg.txc_s2;
		s_next.tri_req = rx_release;

		s_next.rx_valid = 1'b0;
		if (rx_edge) begin
			s_next.rx_in_frame = s_reg.dv_s2;
			s_next.rx_valid = s_reg.dv_s2;
			s_next.rx_data = s_reg.rxd_s2;
			s_next.rx_error = speed_100 && s_reg.er_s2;
		end

		// Change just after the edge so data is settled at the next one
		if (tx_edge) begin
			s_next.tx_en = tx_valid;
			s_next.txd = tx_valid ? tx_data : NIB_ZERO;
			s_next.tx_er = tx_valid && tx_error && speed_100;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign mii.txd = s_reg.txd;
	assign mii.tx_en = s_reg.tx_en;
	assign mii.tx_er = s_reg.tx_er;
	assign mii.rx_bus_tristate_req = s_reg.tri_req;
	assign rx_valid = s_reg.rx_valid;
	assign rx_data = s_reg.rx_data;
	assign rx_error = s_reg.rx_error;
	assign rx_in_frame = s_reg.rx_in_frame;

endmodule

/* File: test/pmdp_props.sv */
`timescale 1ns/1ps
module pmdp_props
	import pmdp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rx_clk_o,
	input wire logic rx_clk_oe,
	input wire logic [NIB_W-1:0] rxd_o,
	input wire logic rxd_oe,
	input wire logic rx_dv_o,
	input wire logic rx_dv_oe,
	input wire logic rx_er_o,
	input wire logic rx_er_oe,
	input wire logic tx_clk,
	input wire logic [NIB_W-1:0] txd,
	input wire logic tx_en,
	input wire logic rx_bus_tristate_req
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [CNT_W-1:0] per_reg;
	logic seen_reg;
	// First rise after reset has no reference, so it is not timed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			per_reg <= CNT_ZERO;
			seen_reg <= 1'b0;
		end else if ($rose(tx_clk)) begin
			per_reg <= CNT_ONE;
			seen_reg <= 1'b1;
		end else begin
			per_reg <= per_reg + CNT_ONE;
		end
	end
	AST_RX_DV_SYNC: assert property ($changed(rx_dv_o) |-> $rose(rx_clk_o))
		else $error("valid moved off a receive clock rise");
	AST_RX_ER_SYNC: assert property ($changed(rx_er_o) |-> $rose(rx_clk_o))
		else $error("error moved off a receive clock rise");
	AST_RXD_SYNC: assert property ($changed(rxd_o) |-> $rose(rx_clk_o))
		else $error("nibble moved off a receive clock rise");
	AST_TRI_FLOAT: assert property (rx_bus_tristate_req [*3] |-> !(rx_clk_oe || rxd_oe || rx_dv_oe || rx_er_oe))
		else $error("receive bus still driven while released");
	AST_TRI_DRIVE: assert property (!rx_bus_tristate_req [*3] |-> rx_clk_oe && rxd_oe && rx_dv_oe && rx_er_oe)
		else $error("receive bus not driven while claimed");
	AST_TX_PERIOD: assert property ($rose(tx_clk) && seen_reg |-> per_reg == DIV_100 || per_reg == DIV_10)
		else $error("transmit clock period wrong");
	AST_TX_HIGH: assert property ($rose(tx_clk) |=> tx_clk [*3])
		else $error("transmit clock high phase too short");
	AST_TX_HOLD: assert property ($rose(tx_clk) |-> $stable(txd) && $stable(tx_en))
		else $error("transmit nibble moved at a clock rise");
	AST_DV_FALL_ER: assert property ($fell(rx_dv_o) |-> !rx_er_o)
		else $error("error left high when valid dropped");
	cover property ($rose(rx_dv_o));
	cover property ($rose(rx_er_o));
	cover property ($rose(rx_bus_tristate_req));
endmodule

/* File: test/phy_mii_data_port_tb.sv */
`timescale 1ns/1ps
module phy_mii_data_port_tb;
	import pmdp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic speed_100 = 1'b1;
	logic link_up = 1'b0, carrier_sense = 1'b0, line_rx_valid = 1'b0;
	logic start_delim_seen = 1'b0, end_delim_seen = 1'b0, signal_error = 1'b0;
	logic false_carrier = 1'b0, frame_error = 1'b0, rx_release = 1'b0;
	logic tx_valid = 1'b0, tx_error = 1'b0, err_seen = 1'b0;
	logic [NIB_W-1:0] line_rx_data = NIB_ZERO, tx_data = NIB_ZERO;
	logic line_rx_ready, line_tx_valid, line_tx_halt, tx_ready;
	logic rx_valid, rx_error, rx_in_frame;
	logic [NIB_W-1:0] line_tx_data, rx_data;
	logic [4:0] tx_q[$];
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;

	always #2.5 clk_sys = ~clk_sys;

	pmdp_mii_if mii();
	pmdp_phy_end u_pmdp_phy_end (.clk_sys(clk_sys), .rst(rst), .mii(mii), .speed_100(speed_100),
		.link_up(link_up), .carrier_sense(carrier_sense), .line_rx_valid(line_rx_valid),
		.line_rx_ready(line_rx_ready), .line_rx_data(line_rx_data), .start_delim_seen(start_delim_seen),
		.end_delim_seen(end_delim_seen), .signal_error(signal_error), .false_carrier(false_carrier),
		.frame_error(frame_error), .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
		.line_tx_halt(line_tx_halt));
	pmdp_mac_end u_pmdp_mac_end (.clk_sys(clk_sys), .rst(rst), .mii(mii), .speed_100(speed_100),
		.rx_release(rx_release), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_error(tx_error), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
		.rx_in_frame(rx_in_frame));
	pmdp_props u_pmdp_props (.clk_sys(clk_sys), .rst(rst), .rx_clk_o(mii.rx_clk_o),
		.rx_clk_oe(mii.rx_clk_oe), .rxd_o(mii.rxd_o), .rxd_oe(mii.rxd_oe), .rx_dv_o(mii.rx_dv_o),
		.rx_dv_oe(mii.rx_dv_oe), .rx_er_o(mii.rx_er_o), .rx_er_oe(mii.rx_er_oe), .tx_clk(mii.tx_clk),
		.txd(mii.txd), .tx_en(mii.tx_en), .rx_bus_tristate_req(mii.rx_bus_tristate_req));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic do_reset(input logic sp);
		rst = 1'b1;
		speed_100 = sp;
		link_up = 1'b0;
		tick(6);
		rst = 1'b0;
		tick(2);
		link_up = 1'b1;
		tick(2);
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (rx_error === 1'b1) begin
			err_seen <= 1'b1;
		end
		if (tx_ready === 1'b1 && tx_valid) begin
			tx_q.push_back({tx_error & speed_100, tx_data});
		end
		if (line_tx_valid === 1'b1) begin
			if (tx_q.size() == 0) begin
				check(8'hff, 8'h00);
			end else begin
				check({3'h0, line_tx_halt, line_tx_data}, {3'h0, tx_q.pop_front()});
			end
		end
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	// Bus must float within eight cycles of release and come back after
	task automatic tri_run();
		rx_release = 1'b1;
		tick(8);
		check({4'h0, mii.rx_clk_oe, mii.rxd_oe, mii.rx_dv_oe, mii.rx_er_oe}, 8'h00);
		rx_release = 1'b0;
		tick(8);
		check({4'h0, mii.rx_clk_oe, mii.rxd_oe, mii.rx_dv_oe, mii.rx_er_oe}, 8'h0f);
		$display("tristate test done");
	endtask

	// Either a false carrier before the frame or a frame error inside it
	task automatic rx_run(input logic sp, input logic fc);
		logic [NIB_W-1:0] nib [4];
		int i;
		int k;
		nib = '{4'h1, 4'ha, 4'h6, 4'hc};
		do_reset(sp);
		err_seen = 1'b0;
		carrier_sense = 1'b1;
		line_rx_valid = 1'b1;
		for (i = 0; i < 4; i++) begin
			line_rx_data = nib[i];
			tick(1);
		end
		line_rx_valid = 1'b0;
		check({7'h0, line_rx_ready}, 8'h00);
		false_carrier = fc;
		tick(1);
		false_carrier = 1'b0;
		tick(100);
		start_delim_seen = 1'b1;
		tick(1);
		start_delim_seen = 1'b0;
		for (i = 0; i < 4; i++) begin
			k = 0;
			while (rx_valid !== 1'b1 && k < 200) begin
				tick(1);
				k++;
			end
			check({3'h0, rx_in_frame, rx_data}, {4'h1, nib[i]});
			if (i > 0) begin
				check(8'(k + 1), sp ? 8'h08 : 8'h50);
			end
			frame_error = !fc && i == 1;
			tick(1);
			frame_error = 1'b0;
		end
		end_delim_seen = sp;
		signal_error = !sp;
		tick(1);
		end_delim_seen = 1'b0;
		signal_error = 1'b0;
		k = 0;
		while (rx_in_frame !== 1'b0 && k < 200) begin
			tick(1);
			k++;
		end
		check({7'h0, rx_in_frame}, 8'h00);
		check({7'h0, err_seen}, {7'h0, sp});
		carrier_sense = 1'b0;
		$display("receive test speed %0d false carrier %0d done", sp, fc);
	endtask

	task automatic tx_run(input logic sp);
		int i;
		int k;
		do_reset(sp);
		tx_valid = 1'b1;
		for (i = 0; i < 4; i++) begin
			tx_data = NIB_W'(i * 5 + 1);
			tx_error = (i == 2);
			k = 0;
			while (tx_ready !== 1'b1 && k < 200) begin
				tick(1);
				k++;
			end
			tick(1);
		end
		tx_valid = 1'b0;
		tx_error = 1'b0;
		tick(200);
		check(8'(tx_q.size()), 8'h00);
		$display("transmit test speed %0d done", sp);
	endtask

	initial begin
		do_reset(1'b1);
		tri_run();
		for (int s = 0; s < 4; s++) begin
			rx_run(s[1], s[0]);
		end
		tx_run(1'b1);
		tx_run(1'b0);
		wrap_up();
	end
endmodule
